// >>> verilog/gsbr_reporter.sv
// What this block does
// - up to eight members share one 8-bit host bus so one read returns a bit from each.
// - reading the interrupt info address on any enabled member returns every enabled member's interrupt.
// - bit 0 of control register A switches group participation on (1) or off (0).
// - bits 1 to 3 of control register A pick which data line n (0 to 7) this member drives.
// - the member drives its group bit only while an info register is being read.
// - bits 0 to 2 of control register B pick the first user status, T1 meanings.
// - in E1 mode those codes mean all-ones, remote, multiframe remote, V5 link, etc.
// - bits 4 to 6 of control register B pick the second user status, same mapping.
// - an interrupt info read makes each enabled member drive its interrupt status.
// - a sync info read makes each enabled member drive its loss-of-sync status.
// - a first user status read makes each enabled member drive its first selection.
// - a second user status read makes each enabled member drive its second selection.
// - members are joined by two shared select pins and one shared read pin.
`timescale 1ns/100ps
`default_nettype none

module gsbr_reporter (
   input wire logic mclk,
   input wire logic nrst,
   // host port pins
   input wire gsbr_pkg::gsbr_host_s hostPins,
   output logic [7:0] hostDataOut,
   output logic [7:0] hostDataOe,
   // shared open-drain group pins, pulled up outside
   input wire logic groupSelectLine0In,
   output logic groupSelectLine0Out,
   output logic groupSelectLine0Oe,
   input wire logic groupSelectLine1In,
   output logic groupSelectLine1Out,
   output logic groupSelectLine1Oe,
   input wire logic groupReadLineIn,
   output logic groupReadLineOut,
   output logic groupReadLineOe,
   // status from the framer, same clock
   input wire logic e1Mode,
   input wire logic memberInterruptBit,
   input wire logic memberSyncLossBit,
   input wire gsbr_pkg::gsbr_alarm_s alarms
);

   gsbr_pkg::gsbr_host_s hostS;
   logic [2:0] grpPinS;
   logic [7:0] ctrlA_q;
   logic [7:0] ctrlA_d;
   logic [7:0] ctrlB_q;
   logic [7:0] ctrlB_d;
   logic wrPrev_q;
   logic wrPrev_d;
   logic [7:0] dataOut_q;
   logic [7:0] dataOut_d;
   logic [7:0] dataOe_q;
   logic [7:0] dataOe_d;
   logic rdOe_q;
   logic rdOe_d;
   logic sel0Oe_q;
   logic sel0Oe_d;
   logic sel1Oe_q;
   logic sel1Oe_d;
   logic pinLow_q;
   logic hostRd;
   logic hostWr;
   logic wrStart;
   logic isInfo;
   logic [7:0] infoOfs;
   logic [1:0] infoIdx;
   logic grpEn;
   logic [2:0] lineSel;
   logic launch;
   logic grpActive;
   gsbr_pkg::gsbr_info_e kind;
   logic userOneBit;
   logic userTwoBit;
   logic statusBit;

   // ==========================================================
   // pin inputs
   // every pin passes two flops before any logic sees it
   gsbr_sync #(
      .WIDTH($bits(gsbr_pkg::gsbr_host_s)),
      .RST_VAL(gsbr_pkg::HOST_IDLE)
   ) u_host_sync (
      .mclk(mclk),
      .nrst(nrst),
      .din(hostPins),
      .dout(hostS)
   );

   // idle level of the pulled-up group pins is high
   gsbr_sync #(
      .WIDTH(3),
      .RST_VAL(3'h7)
   ) u_grp_sync (
      .mclk(mclk),
      .nrst(nrst),
      .din({groupReadLineIn, groupSelectLine1In, groupSelectLine0In}),
      .dout(grpPinS)
   );

   // ==========================================================
   // status selection
   gsbr_status_sel u_usr1_sel (
      .code(ctrlB_q[gsbr_pkg::CTRLB_USR1_LSB +: gsbr_pkg::SEL_WIDTH]),
      .e1Mode(e1Mode),
      .alarms(alarms),
      .statusBit(userOneBit)
   );

   // second user field shares the same mapping
   gsbr_status_sel u_usr2_sel (
      .code(ctrlB_q[gsbr_pkg::CTRLB_USR2_LSB +: gsbr_pkg::SEL_WIDTH]),
      .e1Mode(e1Mode),
      .alarms(alarms),
      .statusBit(userTwoBit)
   );

   // ==========================================================
   // host decode
   always_comb begin
      hostRd = !hostS.csN && !hostS.rdN;
      hostWr = !hostS.csN && !hostS.wrN;
      wrStart = hostWr && !wrPrev_q;
      infoOfs = hostS.addr - gsbr_pkg::OFS_INFO_INT;
      infoIdx = infoOfs[1:0];
      isInfo = (hostS.addr >= gsbr_pkg::OFS_INFO_INT) &&
               (hostS.addr <= gsbr_pkg::OFS_INFO_USR2);
      grpEn = ctrlA_q[gsbr_pkg::CTRLA_EN_BIT];
      lineSel = ctrlA_q[gsbr_pkg::CTRLA_LINE_LSB +: gsbr_pkg::SEL_WIDTH];
   end

   // ==========================================================
   // control registers
   // written once per write strobe; reserved bits are not stored
   always_comb begin
      ctrlA_d = ctrlA_q;
      ctrlB_d = ctrlB_q;
      wrPrev_d = hostWr;
      if (wrStart && hostS.addr == gsbr_pkg::OFS_CTRL_A) begin
         ctrlA_d = hostS.data & gsbr_pkg::CTRLA_MASK;
      end
      if (wrStart && hostS.addr == gsbr_pkg::OFS_CTRL_B) begin
         ctrlB_d = hostS.data & gsbr_pkg::CTRLB_MASK;
      end
      if (!nrst) begin
         ctrlA_d = gsbr_pkg::RST_CTRL_A;
         ctrlB_d = gsbr_pkg::RST_CTRL_B;
         wrPrev_d = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      ctrlA_q <= ctrlA_d;
      ctrlB_q <= ctrlB_d;
      wrPrev_q <= wrPrev_d;
   end

   // ==========================================================
   // shared group pins
   // the addressed member pulls read low and encodes the kind on the
   // select pins; a low pin means a one so idle pull-ups read as zero
   always_comb begin
      launch = hostRd && isInfo && grpEn;
      rdOe_d = launch;
      sel0Oe_d = launch && infoIdx[0];
      sel1Oe_d = launch && infoIdx[1];
      if (!nrst) begin
         rdOe_d = 1'b0;
         sel0Oe_d = 1'b0;
         sel1Oe_d = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      rdOe_q <= rdOe_d;
      sel0Oe_q <= sel0Oe_d;
      sel1Oe_q <= sel1Oe_d;
      pinLow_q <= 1'b0;
   end

   // ==========================================================
   // data line drive
   // every enabled member, the addressed one included, answers the
   // synchronised read pin, so all members switch in the same cycle
   always_comb begin
      grpActive = !grpPinS[2] && grpEn;
      kind = gsbr_pkg::gsbr_info_e'(~grpPinS[1:0]);
      unique case (kind)
         gsbr_pkg::INFO_INT: statusBit = memberInterruptBit;
         gsbr_pkg::INFO_SYNC: statusBit = memberSyncLossBit;
         gsbr_pkg::INFO_USR1: statusBit = userOneBit;
         gsbr_pkg::INFO_USR2: statusBit = userTwoBit;
      endcase
      dataOe_d = 8'h00;
      dataOut_d = 8'h00;
      // only a live group read opens a single line
      if (grpActive) begin
         dataOe_d = 8'h01 << lineSel;
         dataOut_d = statusBit ? dataOe_d : 8'h00;
      end else if (hostRd && hostS.addr == gsbr_pkg::OFS_CTRL_A) begin
         dataOe_d = 8'hFF;
         dataOut_d = ctrlA_q;
      end else if (hostRd && hostS.addr == gsbr_pkg::OFS_CTRL_B) begin
         dataOe_d = 8'hFF;
         dataOut_d = ctrlB_q;
      end else if (hostRd && isInfo && !grpEn) begin
         // a lone disabled member answers its info read with zeros
         dataOe_d = 8'hFF;
      end
      if (!nrst) begin
         dataOe_d = 8'h00;
         dataOut_d = 8'h00;
      end
   end

   always_ff @(posedge mclk) begin
      dataOe_q <= dataOe_d;
      dataOut_q <= dataOut_d;
   end

   assign hostDataOut = dataOut_q;
   assign hostDataOe = dataOe_q;
   assign groupReadLineOut = pinLow_q;
   assign groupReadLineOe = rdOe_q;
   assign groupSelectLine0Out = pinLow_q;
   assign groupSelectLine0Oe = sel0Oe_q;
   assign groupSelectLine1Out = pinLow_q;
   assign groupSelectLine1Oe = sel1Oe_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   property p_line_onehot;
      grpActive |=> (dataOe_q == (8'h01 << $past(lineSel)));
   endproperty
   a_line_onehot: assert property (p_line_onehot)
      else $error("group drive not on the selected line");

   property p_only_in_read;
      (dataOe_q != 8'h00 && dataOe_q != 8'hFF) |-> $past(grpActive);
   endproperty
   a_only_in_read: assert property (p_only_in_read)
      else $error("single line driven outside a group read");

   property p_disabled_quiet;
      (!grpEn && $past(!grpEn)) |->
         !rdOe_q && !sel0Oe_q && !sel1Oe_q && !$onehot(dataOe_q);
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet)
      else $error("disabled member drives group pins");

   property p_enable_write;
      (wrStart && hostS.addr == gsbr_pkg::OFS_CTRL_A) |=>
         grpEn == $past(hostS.data[0]);
   endproperty
   a_enable_write: assert property (p_enable_write)
      else $error("enable bit did not follow the write");

   property p_launch;
      launch |=> rdOe_q && (sel0Oe_q == $past(infoIdx[0])) && (sel1Oe_q == $past(infoIdx[1]));
   endproperty
   a_launch: assert property (p_launch)
      else $error("addressed member did not signal the group read");

   property p_int_bit;
      (grpActive && kind == gsbr_pkg::INFO_INT) |=>
         |(dataOut_q & dataOe_q) == $past(memberInterruptBit);
   endproperty
   a_int_bit: assert property (p_int_bit)
      else $error("interrupt bit wrong on the bus");

   property p_sync_bit;
      (grpActive && kind == gsbr_pkg::INFO_SYNC) |=>
         |(dataOut_q & dataOe_q) == $past(memberSyncLossBit);
   endproperty
   a_sync_bit: assert property (p_sync_bit)
      else $error("sync loss bit wrong on the bus");

   property p_usr1_bit;
      (grpActive && kind == gsbr_pkg::INFO_USR1) |=>
         |(dataOut_q & dataOe_q) == $past(userOneBit);
   endproperty
   a_usr1_bit: assert property (p_usr1_bit)
      else $error("first user status wrong on the bus");

   property p_usr2_bit;
      (grpActive && kind == gsbr_pkg::INFO_USR2) |=>
         |(dataOut_q & dataOe_q) == $past(userTwoBit);
   endproperty
   a_usr2_bit: assert property (p_usr2_bit)
      else $error("second user status wrong on the bus");

   property p_undefined_code;
      (ctrlB_q[2:0] == 3'h6 || ctrlB_q[2:0] == 3'h7) |-> !userOneBit;
   endproperty
   a_undefined_code: assert property (p_undefined_code)
      else $error("undefined code reports a status");

endmodule

`default_nettype wire

// >>> verilog/gsbr_pkg.sv
package gsbr_pkg;

   // ==========================================================
   // register offsets on the host port
   localparam logic [7:0] OFS_CTRL_A = 8'hB0;
   localparam logic [7:0] OFS_CTRL_B = 8'hB1;
   localparam logic [7:0] OFS_INFO_INT = 8'hB2;
   localparam logic [7:0] OFS_INFO_SYNC = 8'hB3;
   localparam logic [7:0] OFS_INFO_USR1 = 8'hB4;
   localparam logic [7:0] OFS_INFO_USR2 = 8'hB5;

   // ==========================================================
   // reset values and field layout
   localparam logic [7:0] RST_CTRL_A = 8'h00;
   localparam logic [7:0] RST_CTRL_B = 8'h00;
   localparam int CTRLA_EN_BIT = 0;
   localparam int CTRLA_LINE_LSB = 1;
   localparam int CTRLB_USR1_LSB = 0;
   localparam int CTRLB_USR2_LSB = 4;
   localparam int SEL_WIDTH = 3;
   localparam logic [7:0] CTRLA_MASK = 8'h0F;
   localparam logic [7:0] CTRLB_MASK = 8'h77;

   // ==========================================================
   // user status codes, 6 and 7 report nothing
   localparam logic [2:0] USR_BLUE_OR_AIS = 3'h0;
   localparam logic [2:0] USR_YEL_OR_RA = 3'h1;
   localparam logic [2:0] USR_LUP_OR_MFRA = 3'h2;
   localparam logic [2:0] USR_LDN_OR_V5 = 3'h3;
   localparam logic [2:0] USR_SIGNALING_CHANGE = 3'h4;
   localparam logic [2:0] USR_SLIP = 3'h5;

   // kind of group read, carried on the two shared select pins
   typedef enum logic [1:0] {INFO_INT, INFO_SYNC, INFO_USR1, INFO_USR2} gsbr_info_e;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic csN;
      logic rdN;
      logic wrN;
      logic [7:0] addr;
      logic [7:0] data;
   } gsbr_host_s;

   typedef struct packed {
      logic blueAlarm;
      logic yellowAlarm;
      logic loopUpDetect;
      logic loopDownDetect;
      logic unframedAllOnes;
      logic remoteAlarm;
      logic multiframeRemoteAlarm;
      logic v5LinkIdDetect;
      logic signalingChange;
      logic elasticStoreSlip;
   } gsbr_alarm_s;

   localparam gsbr_host_s HOST_IDLE = '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1,
                                       addr: 8'h00, data: 8'h00};

endpackage

// >>> verilog/gsbr_sync.sv
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser for pin inputs; stage one feeds stage two only
module gsbr_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // ==========================================================
   // next values
   always_comb begin
      meta_d = din;
      sync_d = meta_q;
      if (!nrst) begin
         meta_d = RST_VAL;
         sync_d = RST_VAL;
      end
   end

   always_ff @(posedge mclk) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
   end

   assign dout = sync_q;

endmodule

`default_nettype wire

// >>> verilog/gsbr_status_sel.sv
`timescale 1ns/100ps
`default_nettype none

// picks one alarm by select code; framing mode changes the meaning
module gsbr_status_sel (
   input wire logic [2:0] code,
   input wire logic e1Mode,
   input wire gsbr_pkg::gsbr_alarm_s alarms,
   output logic statusBit
);

   // codes 6 and 7 are undefined and report a quiet zero
   always_comb begin
      unique case (code)
         gsbr_pkg::USR_BLUE_OR_AIS: statusBit = e1Mode ? alarms.unframedAllOnes
                                                       : alarms.blueAlarm;
         gsbr_pkg::USR_YEL_OR_RA: statusBit = e1Mode ? alarms.remoteAlarm
                                                     : alarms.yellowAlarm;
         gsbr_pkg::USR_LUP_OR_MFRA: statusBit = e1Mode ? alarms.multiframeRemoteAlarm
                                                       : alarms.loopUpDetect;
         gsbr_pkg::USR_LDN_OR_V5: statusBit = e1Mode ? alarms.v5LinkIdDetect
                                                     : alarms.loopDownDetect;
         gsbr_pkg::USR_SIGNALING_CHANGE: statusBit = alarms.signalingChange;
         gsbr_pkg::USR_SLIP: statusBit = alarms.elasticStoreSlip;
         3'h6: statusBit = 1'b0;
         3'h7: statusBit = 1'b0;
      endcase
   end

endmodule

`default_nettype wire

// >>> testbench/gsbr_peer_model.sv
`timescale 1ns/100ps
`default_nettype none

// another member of the group, sitting on its own data line
module gsbr_peer_model #(
   parameter logic [2:0] LINE = 3'h5
) (
   input wire logic mclk,
   input wire logic readWire,
   input wire logic sel0Wire,
   input wire logic sel1Wire,
   input wire logic [3:0] status,
   output logic [7:0] dataOe,
   output logic [7:0] dataOut
);
   logic [1:0] seen;
   logic lastBit;

   initial begin
      seen = 2'h0;
      lastBit = 1'b0;
   end

   // ==========================================================
   // notice the shared read line through two flops, like a real pin
   always @(posedge mclk) begin
      seen <= {seen[0], ~readWire};
      if (dataOe[LINE]) begin
         lastBit <= dataOut[LINE];
      end
   end

   // own line only while the read line is low; released line shows junk
   always_comb begin
      dataOe = 8'h00;
      dataOut = 8'h00;
      dataOe[LINE] = seen[1] & ~readWire;
      dataOut[LINE] = dataOe[LINE] ? status[{~sel1Wire, ~sel0Wire}] : ~lastBit;
   end
endmodule

`default_nettype wire

// >>> testbench/test_grouped_status_bus_reporter.sv
`timescale 1ns/100ps
`default_nettype none

module test_grouped_status_bus_reporter;
   logic mclk, nrst, e1, intBit, lossBit, grpSeen;
   gsbr_pkg::gsbr_host_s host;
   gsbr_pkg::gsbr_alarm_s alarms;
   logic [7:0] dOut, dOe, pOut, pOe, oeS, outS;
   logic s0Out, s0Oe, s1Out, s1Oe, rdOut, rdOe, s0W, s1W, rdW, busS;
   logic extRd;
   logic [2:0] grpS;
   logic [3:0] peerStat;
   int mismatches, n_tests, cycles;

   // open-drain wires with pull-ups: low when any party pulls
   assign s0W = !(s0Oe && !s0Out);
   assign s1W = !(s1Oe && !s1Out);
   // extRd stands for another addressed member pulling the read line
   assign rdW = !(rdOe && !rdOut) && !extRd;

   gsbr_reporter i_gsbr_reporter (.mclk(mclk), .nrst(nrst), .hostPins(host),
      .hostDataOut(dOut), .hostDataOe(dOe), .groupSelectLine0In(s0W),
      .groupSelectLine0Out(s0Out), .groupSelectLine0Oe(s0Oe), .groupSelectLine1In(s1W),
      .groupSelectLine1Out(s1Out), .groupSelectLine1Oe(s1Oe), .groupReadLineIn(rdW),
      .groupReadLineOut(rdOut), .groupReadLineOe(rdOe), .e1Mode(e1),
      .memberInterruptBit(intBit), .memberSyncLossBit(lossBit), .alarms(alarms));

   gsbr_peer_model i_gsbr_peer_model (.mclk(mclk), .readWire(rdW), .sel0Wire(s0W),
      .sel1Wire(s1W), .status(peerStat), .dataOe(pOe), .dataOut(pOut));

   // ==========================================================
   // clock, hang guard and group pin watch
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (rdOe || s0Oe || s1Oe) begin
         grpSeen = 1'b1;
      end
      if (cycles == 5000) begin
         mismatches++;
         results();
      end
   end

   // ==========================================================
   // shared helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one host access, held long enough for a group read, then idle
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      host = '{csN: 1'b0, rdN: wr, wrN: !wr, addr: a, data: d};
      repeat (8) @(negedge mclk);
      oeS = dOe;
      outS = dOut;
      grpS = {rdOe, s1Oe, s0Oe};
      busS = pOe[5] ? pOut[5] : 1'bx;
      host = gsbr_pkg::HOST_IDLE;
      repeat (9) @(negedge mclk);
      check(dOe, 8'h00);
   endtask

   // status vector with only the field that a code names set
   function automatic gsbr_pkg::gsbr_alarm_s pick(input logic [2:0] c, input logic e);
      if (c > 3'h5) begin
         return '0;
      end
      return gsbr_pkg::gsbr_alarm_s'(10'h200 >> (int'(c) + ((c > 3'h3 || e) ? 4 : 0)));
   endfunction

   // ==========================================================
   // scenarios
   task automatic t_regs;
      access(1'b0, gsbr_pkg::OFS_CTRL_A, 8'h00);
      check(oeS, 8'hFF);
      check(outS, gsbr_pkg::RST_CTRL_A);
      access(1'b0, gsbr_pkg::OFS_CTRL_B, 8'h00);
      check(outS, gsbr_pkg::RST_CTRL_B);
      access(1'b1, gsbr_pkg::OFS_CTRL_A, 8'h0F);
      access(1'b1, gsbr_pkg::OFS_CTRL_B, 8'h77);
      access(1'b1, 8'hB6, 8'h00);
      access(1'b0, 8'hB6, 8'h00);
      check(oeS, 8'h00);
      access(1'b0, gsbr_pkg::OFS_CTRL_A, 8'h00);
      check(outS, 8'h0F);
      access(1'b0, gsbr_pkg::OFS_CTRL_B, 8'h00);
      check(outS, 8'h77);
      $display("register test done");
   endtask

   task automatic t_lines;
      for (int n = 0; n < 8; n++) begin
         intBit = n[0];
         access(1'b1, gsbr_pkg::OFS_CTRL_A, {4'h0, 3'(n), 1'b1});
         access(1'b0, gsbr_pkg::OFS_INFO_INT, 8'h00);
         check(oeS, 8'(8'h01 << n));
         check({7'h00, outS[n]}, {7'h00, intBit});
         check({5'h00, grpS}, 8'h04);
      end
      $display("line select test done");
   endtask

   task automatic t_off;
      access(1'b1, gsbr_pkg::OFS_CTRL_A, 8'h06);
      grpSeen = 1'b0;
      access(1'b0, gsbr_pkg::OFS_INFO_INT, 8'h00);
      check(oeS, 8'hFF);
      check(outS, 8'h00);
      check({7'h00, grpSeen}, 8'h00);
      // another member starts a group read; this one must stay quiet
      extRd = 1'b1;
      repeat (8) @(negedge mclk);
      check({7'h00, pOe[5]}, 8'h01);
      check(dOe, 8'h00);
      check({7'h00, grpSeen}, 8'h00);
      extRd = 1'b0;
      repeat (9) @(negedge mclk);
      $display("disabled member test done");
   endtask

   // every kind of group read, with a peer answering on line 5
   task automatic t_kinds;
      access(1'b1, gsbr_pkg::OFS_CTRL_A, 8'h05);
      access(1'b1, gsbr_pkg::OFS_CTRL_B, 8'h10);
      peerStat = 4'h5;
      for (int k = 0; k < 4; k++) begin
         intBit = (k == 0);
         lossBit = (k == 1);
         alarms = pick(3'(k - 2), 1'b0);
         access(1'b0, 8'(8'hB2 + k), 8'h00);
         check(oeS, 8'h04);
         check({7'h00, outS[2]}, 8'h01);
         check({5'h00, grpS}, 8'(4 + k));
         check({7'h00, busS}, {7'h00, ~k[0]});
      end
      // enabled member answers a group read that another member started
      intBit = 1'b1;
      extRd = 1'b1;
      repeat (8) @(negedge mclk);
      check(dOe, 8'h04);
      check({7'h00, dOut[2]}, 8'h01);
      extRd = 1'b0;
      repeat (9) @(negedge mclk);
      $display("group read test done");
   endtask

   task automatic t_user;
      for (int m = 0; m < 32; m++) begin
         e1 = m[4];
         access(1'b1, gsbr_pkg::OFS_CTRL_B, {1'b0, 3'(m), 1'b0, 3'(m)});
         alarms = m[3] ? ~pick(3'(m), e1) : pick(3'(m), e1);
         access(1'b0, gsbr_pkg::OFS_INFO_USR1, 8'h00);
         check({7'h00, outS[2]}, {7'h00, !m[3] && m[2:0] < 6});
         access(1'b0, gsbr_pkg::OFS_INFO_USR2, 8'h00);
         check({7'h00, outS[2]}, {7'h00, !m[3] && m[2:0] < 6});
      end
      $display("user status test done");
   endtask

   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      mclk = 1'b0;
      nrst = 1'b0;
      host = gsbr_pkg::HOST_IDLE;
      {e1, intBit, lossBit, grpSeen} = 4'h0;
      extRd = 1'b0;
      alarms = '0;
      peerStat = 4'h0;
      {mismatches, n_tests, cycles} = '0;
      repeat (5) @(negedge mclk);
      nrst = 1'b1;
      @(negedge mclk);
      t_regs();
      t_lines();
      t_off();
      t_kinds();
      t_user();
      results();
   end
endmodule

`default_nettype wire
